// File: common/sgdc_pkg.sv
// constants and types shared by the pin, strap and data path register slice
package sgdc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned STRAP_SETTLE_NS = 10000;
    // least time, so round up to whole cycles
    localparam int unsigned STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_PIN_CFG = 6'h11;
    localparam logic [5:0] IDX_DP_CTRL = 6'h12;
    localparam logic [5:0] IDX_STRAP = 6'h13;
    localparam logic [5:0] IDX_PIN_IN = 6'h18;

    // ------------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    localparam logic [7:0] RST_DP_CTRL = 8'h00;
    localparam logic [7:0] RST_STRAP = 8'h88;
    localparam logic [7:0] MASK_PIN_CFG = 8'hbb;
    localparam logic [7:0] MASK_DP_CTRL = 8'h7f;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned PIN8_OUT_BIT = 7;
    localparam int unsigned PIN8_MODE_LSB = 4;
    localparam int unsigned PIN7_OUT_BIT = 3;
    localparam int unsigned PIN7_MODE_LSB = 0;
    localparam int unsigned ST_DONE1_BIT = 7;
    localparam int unsigned ST_DEC1_LSB = 4;
    localparam int unsigned ST_DONE0_BIT = 3;
    localparam int unsigned ST_DEC0_LSB = 0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_FUNC = 2'h0,
        PM_GP_OUT = 2'h1,
        PM_HIZ = 2'h2,
        PM_GP_IN = 2'h3
    } sgdc_pin_mode_t;

    typedef struct packed {
        logic rsvd;
        logic bypass;
        logic dv_pol;
        logic regen;
        logic b_ovr;
        logic w18;
        logic xport;
        logic b_en;
    } sgdc_dp_ctrl_t;

    typedef struct packed {
        logic done;
        logic [2:0] dec;
    } sgdc_strap_t;

endpackage : sgdc_pkg

// File: logic/sgdc_pin_ctrl.sv
// one general-purpose pin: mode decode, pad drive and input sampling
`timescale 1ns/1ps
module sgdc_pin_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input sgdc_pkg::sgdc_pin_mode_t mode,
    input wire logic out_val,
    // pad
    input wire logic pad_in,
    output logic pad_out_q,
    output logic pad_oe_n_q,
    // sampled input
    output logic func_in_q,
    output logic gpio_in_q
);

    logic pad_s1_q;
    logic pad_s2_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_s1_q <= 1'b0;
            pad_s2_q <= 1'b0;
        end else begin
            pad_s1_q <= pad_in;
            pad_s2_q <= pad_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_out_q <= 1'b0;
            pad_oe_n_q <= 1'b1;
        end else begin
            case (mode)
                sgdc_pkg::PM_GP_OUT: begin
                    pad_out_q <= out_val;
                    pad_oe_n_q <= 1'b0;
                end
                default: begin
                    // functional, high impedance or gp input: release
                    pad_out_q <= 1'b0;
                    pad_oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            func_in_q <= 1'b0;
            gpio_in_q <= 1'b0;
        end else begin
            func_in_q <= (mode == sgdc_pkg::PM_FUNC) & pad_s2_q;
            gpio_in_q <= (mode == sgdc_pkg::PM_GP_IN) & pad_s2_q;
        end
    end

    gp_out_drive_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode == sgdc_pkg::PM_GP_OUT
        |=> !pad_oe_n_q && pad_out_q == $past(out_val))
        else $error("pin not driving output value in gp output mode");

    hiz_release_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode != sgdc_pkg::PM_GP_OUT |=> pad_oe_n_q && !pad_out_q)
        else $error("pin driven outside gp output mode");

endmodule : sgdc_pin_ctrl

// File: logic/sgdc_strap_latch.sv
// multi-level strap: synchronise decoded level, wait to settle, latch once
`timescale 1ns/1ps
module sgdc_strap_latch #(
    parameter int unsigned SETTLE_CYC = sgdc_pkg::STRAP_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level from the strap comparators
    input wire logic [2:0] level,
    // latched result
    output sgdc_pkg::sgdc_strap_t strap_q
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETTLE = 3'b010,
        ST_DONE = 3'b100
    } sgdc_strap_st_t;

    sgdc_strap_st_t state_q;
    logic [2:0] lvl_s1_q;
    logic [2:0] lvl_s2_q;
    logic [2:0] lvl_prev_q;
    logic [15:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lvl_s1_q <= 3'h0;
            lvl_s2_q <= 3'h0;
            lvl_prev_q <= 3'h0;
        end else begin
            lvl_s1_q <= level;
            lvl_s2_q <= lvl_s1_q;
            lvl_prev_q <= lvl_s2_q;
        end
    end

    // level must hold unchanged for the full settle time before latching
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            strap_q <= '{done: 1'b1, dec: 3'h0};
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // let the two sync stages fill; the reset zero left in lvl_prev_q counts once if the level is zero
                    if (cnt_q == 16'h0001) begin
                        state_q <= ST_SETTLE;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                    strap_q.done <= 1'b0;
                end
                ST_SETTLE: begin
                    if (lvl_s2_q != lvl_prev_q) begin
                        cnt_q <= 16'h0000;
                    end else if (cnt_q >= 16'(SETTLE_CYC - 1)) begin
                        state_q <= ST_DONE;
                        strap_q <= '{done: 1'b1, dec: lvl_s2_q};
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    latched_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == ST_DONE |=> strap_q.done && $stable(strap_q.dec))
        else $error("strap result changed after latching");

endmodule : sgdc_strap_latch

// File: logic/sgdc_cfg_top.sv
// apb register slice: pin pair config, data path control, strap status
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module sgdc_cfg_top #(
    parameter int unsigned STRAP_SETTLE_CYC = sgdc_pkg::STRAP_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // general-purpose pin seven
    input wire logic aux_pin_seven_in,
    output logic aux_pin_seven_out,
    output logic aux_pin_seven_oe_n,
    output logic aux_pin_seven_func,
    // general-purpose pin eight
    input wire logic aux_pin_eight_in,
    output logic aux_pin_eight_out,
    output logic aux_pin_eight_oe_n,
    output logic aux_pin_eight_func,
    // strap comparator levels
    input wire logic [2:0] strap_pin_first_level,
    input wire logic [2:0] strap_pin_second_level,
    // video and audio path
    input wire logic pixel_valid_strobe,
    input wire logic repeater_mode,
    input wire logic inband_two_ch,
    output logic colour_data_en,
    output logic audio_packet_en,
    output logic video_18bit,
    output logic audio_in_frame,
    output logic audio_regen,
    output logic second_audio_en
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [5:0] idx);
        reg_hit = (a[1:0] == 2'b00) && (a[7:2] == idx);
    endfunction : reg_hit

    function automatic logic any_hit(input logic [7:0] a);
        any_hit = reg_hit(a, sgdc_pkg::IDX_PIN_CFG)
            || reg_hit(a, sgdc_pkg::IDX_DP_CTRL)
            || reg_hit(a, sgdc_pkg::IDX_STRAP)
            || reg_hit(a, sgdc_pkg::IDX_PIN_IN);
    endfunction : any_hit

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] pin_cfg_q;
    sgdc_pkg::sgdc_dp_ctrl_t dp_q;
    sgdc_pkg::sgdc_strap_t strap0;
    sgdc_pkg::sgdc_strap_t strap1;
    logic [7:0] strap_rd;
    logic gp_in7;
    logic gp_in8;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_val;
    logic strobe_s1_q;
    logic strobe_s2_q;
    logic colour_en_q;
    logic audio_pkt_q;
    logic w18_q;
    logic xport_q;
    logic regen_q;
    logic b_en_q;
    logic b_en_d;
    logic access;
    logic commit;

    assign access = psel & penable;
    assign commit = access & pready_q;

    // ------------------------------------------------------------------
    // apb handshake: one wait state, answer registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access & !pready_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_q <= !any_hit(paddr);
        end else if (commit) begin
            pslverr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        strap_rd = 8'h00;
        strap_rd[sgdc_pkg::ST_DONE1_BIT] = strap1.done;
        strap_rd[sgdc_pkg::ST_DEC1_LSB +: 3] = strap1.dec;
        strap_rd[sgdc_pkg::ST_DONE0_BIT] = strap0.done;
        strap_rd[sgdc_pkg::ST_DEC0_LSB +: 3] = strap0.dec;
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (reg_hit(paddr, sgdc_pkg::IDX_PIN_CFG)) begin
            rd_val[7:0] = pin_cfg_q & sgdc_pkg::MASK_PIN_CFG;
        end else if (reg_hit(paddr, sgdc_pkg::IDX_DP_CTRL)) begin
            rd_val[7:0] = dp_q & sgdc_pkg::MASK_DP_CTRL;
        end else if (reg_hit(paddr, sgdc_pkg::IDX_STRAP)) begin
            rd_val[7:0] = strap_rd;
        end else if (reg_hit(paddr, sgdc_pkg::IDX_PIN_IN)) begin
            rd_val[1:0] = {gp_in8, gp_in7};
        end
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // reserved bits are masked on the way in, so they can never set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_cfg_q <= sgdc_pkg::RST_PIN_CFG;
        end else if (commit && pwrite
                     && reg_hit(paddr, sgdc_pkg::IDX_PIN_CFG)) begin
            pin_cfg_q <= pwdata[7:0] & sgdc_pkg::MASK_PIN_CFG;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dp_q <= sgdc_pkg::RST_DP_CTRL;
        end else if (commit && pwrite
                     && reg_hit(paddr, sgdc_pkg::IDX_DP_CTRL)) begin
            dp_q <= pwdata[7:0] & sgdc_pkg::MASK_DP_CTRL;
        end
    end

    // ------------------------------------------------------------------
    // general-purpose pins
    // ------------------------------------------------------------------
    sgdc_pin_ctrl u_pin_seven (
        .clk(clk),
        .rst_n(rst_n),
        .mode(sgdc_pkg::sgdc_pin_mode_t'(
            pin_cfg_q[sgdc_pkg::PIN7_MODE_LSB +: 2])),
        .out_val(pin_cfg_q[sgdc_pkg::PIN7_OUT_BIT]),
        .pad_in(aux_pin_seven_in),
        .pad_out_q(aux_pin_seven_out),
        .pad_oe_n_q(aux_pin_seven_oe_n),
        .func_in_q(aux_pin_seven_func),
        .gpio_in_q(gp_in7)
    );

    sgdc_pin_ctrl u_pin_eight (
        .clk(clk),
        .rst_n(rst_n),
        .mode(sgdc_pkg::sgdc_pin_mode_t'(
            pin_cfg_q[sgdc_pkg::PIN8_MODE_LSB +: 2])),
        .out_val(pin_cfg_q[sgdc_pkg::PIN8_OUT_BIT]),
        .pad_in(aux_pin_eight_in),
        .pad_out_q(aux_pin_eight_out),
        .pad_oe_n_q(aux_pin_eight_oe_n),
        .func_in_q(aux_pin_eight_func),
        .gpio_in_q(gp_in8)
    );

    // ------------------------------------------------------------------
    // strap latches
    // ------------------------------------------------------------------
    sgdc_strap_latch #(
        .SETTLE_CYC(STRAP_SETTLE_CYC)
    ) u_strap_first (
        .clk(clk),
        .rst_n(rst_n),
        .level(strap_pin_first_level),
        .strap_q(strap0)
    );

    sgdc_strap_latch #(
        .SETTLE_CYC(STRAP_SETTLE_CYC)
    ) u_strap_second (
        .clk(clk),
        .rst_n(rst_n),
        .level(strap_pin_second_level),
        .strap_q(strap1)
    );

    // ------------------------------------------------------------------
    // video and audio path controls
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobe_s1_q <= 1'b0;
            strobe_s2_q <= 1'b0;
        end else begin
            strobe_s1_q <= pixel_valid_strobe;
            strobe_s2_q <= strobe_s1_q;
        end
    end

    // bypass wins over the strobe; packet audio has no slot in bypass
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            colour_en_q <= 1'b0;
            audio_pkt_q <= 1'b1;
        end else begin
            colour_en_q <= dp_q.bypass
                | (strobe_s2_q ^ dp_q.dv_pol);
            audio_pkt_q <= !dp_q.bypass;
        end
    end

    // override forces the register bit; otherwise a repeater follows
    // in-band detection and a plain serializer keeps the register bit
    always_comb begin
        if (dp_q.b_ovr) begin
            b_en_d = dp_q.b_en;
        end else if (repeater_mode) begin
            b_en_d = inband_two_ch;
        end else begin
            b_en_d = dp_q.b_en;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w18_q <= 1'b0;
            xport_q <= 1'b0;
            regen_q <= 1'b0;
            b_en_q <= 1'b0;
        end else begin
            w18_q <= dp_q.w18;
            xport_q <= dp_q.xport;
            regen_q <= repeater_mode & dp_q.regen;
            b_en_q <= b_en_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign colour_data_en = colour_en_q;
    assign audio_packet_en = audio_pkt_q;
    assign video_18bit = w18_q;
    assign audio_in_frame = xport_q;
    assign audio_regen = regen_q;
    assign second_audio_en = b_en_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    dp_write_mask_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        commit && pwrite && reg_hit(paddr, sgdc_pkg::IDX_DP_CTRL)
        |=> dp_q == ($past(pwdata[7:0]) & sgdc_pkg::MASK_DP_CTRL))
        else $error("data path control write not stored as masked");

    pin_write_mask_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        commit && pwrite && reg_hit(paddr, sgdc_pkg::IDX_PIN_CFG)
        |=> pin_cfg_q == ($past(pwdata[7:0]) & sgdc_pkg::MASK_PIN_CFG))
        else $error("pin config write not stored as masked");

    bypass_colour_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        dp_q.bypass |=> colour_data_en && !audio_packet_en)
        else $error("bypass did not force colour and block audio");

    strobe_pol_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !dp_q.bypass |=> colour_data_en == $past(strobe_s2_q ^ dp_q.dv_pol))
        else $error("strobe polarity not applied");

    b_override_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        dp_q.b_ovr ##1 dp_q.b_ovr |-> second_audio_en == $past(dp_q.b_en))
        else $error("second audio override not followed");

    b_inband_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !dp_q.b_ovr && repeater_mode
        |=> second_audio_en == $past(inband_two_ch))
        else $error("repeater in-band detection not followed");

    b_plain_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !dp_q.b_ovr && !repeater_mode
        |=> second_audio_en == $past(dp_q.b_en))
        else $error("second audio enable not following its bit");

    regen_gate_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> audio_regen == $past(repeater_mode && dp_q.regen))
        else $error("audio regeneration select wrong");

    width_xport_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> video_18bit == $past(dp_q.w18)
            && audio_in_frame == $past(dp_q.xport))
        else $error("width or transport select lagging");

    strap_read_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        access && !pready_q && !pwrite && reg_hit(paddr, sgdc_pkg::IDX_STRAP)
        |=> prdata[7:0] == {$past(strap1), $past(strap0)} && pready)
        else $error("strap status read wrong");

    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready |-> prdata[31:8] == 24'h000000 && !(pready
            && reg_hit(paddr, sgdc_pkg::IDX_PIN_CFG)
            && (prdata[6] || prdata[2])))
        else $error("reserved bits read nonzero");

    apb_wait_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        access && !pready_q |=> pready ##1 !pready)
        else $error("apb answer not one wait state");

endmodule : sgdc_cfg_top

// File: verif/tb_top.sv
// self-checking bench for the pin, data path and strap register slice
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk, rst_n, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, rerr;
    logic in7, in8, stb, rep, inb;
    logic out7, oe7, fn7, out8, oe8, fn8;
    logic cde, ape, v18, aif, rgn, sae;
    logic [2:0] lvl0, lvl1;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;

    // settle count kept short so the strap latches quickly
    sgdc_cfg_top #(.STRAP_SETTLE_CYC(4)) dut (
        .clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr),
        .aux_pin_seven_in(in7), .aux_pin_seven_out(out7),
        .aux_pin_seven_oe_n(oe7), .aux_pin_seven_func(fn7),
        .aux_pin_eight_in(in8), .aux_pin_eight_out(out8),
        .aux_pin_eight_oe_n(oe8), .aux_pin_eight_func(fn8),
        .strap_pin_first_level(lvl0), .strap_pin_second_level(lvl1),
        .pixel_valid_strobe(stb), .repeater_mode(rep),
        .inband_two_ch(inb), .colour_data_en(cde),
        .audio_packet_en(ape), .video_18bit(v18), .audio_in_frame(aif),
        .audio_regen(rgn), .second_audio_en(sae)
    );

    // ------------------------------------------------------------------
    // clock, timeout and tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run is well under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            $display("Error at %0t: run timed out", $time);
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("Error at %0t: no pready", $time);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic experr, input string what);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, what);
        chk({31'h0, rerr}, {31'h0, experr}, what);
    endtask : rd_chk

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] v, dp;
        logic [1:0] m7, m8;
        logic [5:0] e;
        logic [7:0] dps [10];
        dps = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h09, 8'h10, 8'h20,
                8'h40, 8'h60};
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        in7 = 1'b0;
        in8 = 1'b0;
        stb = 1'b0;
        rep = 1'b0;
        inb = 1'b0;
        lvl0 = 3'h5;
        lvl1 = 3'h2;
        wait_clk(5);
        rst_n <= 1'b1;
        chk({ape, oe7, oe8}, 32'h7, "reset outputs");
        rd_chk(8'h44, 32'h0, 1'b0, "pin cfg reset");
        rd_chk(8'h48, 32'h0, 1'b0, "path reset");
        wait_clk(20);
        rd_chk(8'h4c, 32'had, 1'b0, "strap");
        apb(1'b1, 8'h4c, 32'h0);
        rd_chk(8'h4c, 32'had, 1'b0, "strap write");
        $display("test strap done");
        for (int j = 0; j < 8; j++) begin
            m8 = j[1:0];
            m7 = ~m8;
            in8 <= j[2];
            in7 <= ~j[2];
            v = {j[2], 1'b1, m8, ~j[2], 1'b1, m7};
            apb(1'b1, 8'h44, {24'h0, v});
            wait_clk(4);
            rd_chk(8'h44, {24'h0, v & 8'hbb}, 1'b0, "pin cfg");
            chk({out8, oe8, fn8}, {(m8 == 2'h1) & j[2], m8 != 2'h1,
                (m8 == 2'h0) & j[2]}, "pin eight");
            chk({out7, oe7, fn7}, {(m7 == 2'h1) & ~j[2], m7 != 2'h1,
                (m7 == 2'h0) & ~j[2]}, "pin seven");
            rd_chk(8'h60, {(m8 == 2'h3) & j[2], (m7 == 2'h3) & ~j[2]},
                   1'b0, "pin input");
        end
        $display("test pins done");
        for (int k = 0; k < 40; k++) begin
            dp = dps[k / 4];
            rep <= k[0];
            stb <= k[1];
            inb <= ~k[1];
            apb(1'b1, 8'h48, {24'h0, dp});
            wait_clk(4);
            e = {dp[6] | (k[1] ^ dp[5]), ~dp[6], dp[2], dp[1], k[0] & dp[4],
                 dp[3] ? dp[0] : (k[0] ? ~k[1] : dp[0])};
            chk({cde, ape, v18, aif, rgn, sae}, e,
                "path");
        end
        apb(1'b1, 8'h48, 32'hffff_ffff);
        rd_chk(8'h48, 32'h7f, 1'b0, "path mask");
        $display("test path done");
        rd_chk(8'h50, 32'h0, 1'b1, "unmapped");
        rd_chk(8'h49, 32'h0, 1'b1, "misaligned");
        apb(1'b1, 8'h50, 32'h0);
        rd_chk(8'h48, 32'h7f, 1'b0, "path kept");
        $display("test refusal done");
        lvl0 <= 3'h7;
        lvl1 <= 3'h0;
        rst_n <= 1'b0;
        wait_clk(2);
        rst_n <= 1'b1;
        rd_chk(8'h48, 32'h0, 1'b0, "path rereset");
        wait_clk(20);
        rd_chk(8'h4c, 32'h8f, 1'b0, "strap again");
        $display("test second reset done");
        results();
    end
endmodule : tb_top
